/* File: cal_pkg.sv */
// Purpose: Shared constants and types for the converter calibration control block
// Assumes: 10 MHz system clock, plain register port with one-cycle read latency
// Notes: Register offsets are word indices on the plain port
package cal_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_OFS0 = 4'h3;
  localparam logic [3:0] ADDR_GAIN0 = 4'h4;
  localparam logic [3:0] ADDR_OFS1 = 4'h5;
  localparam logic [3:0] ADDR_GAIN1 = 4'h6;
  localparam logic [3:0] ADDR_RATE = 4'h7;

  // ****************************************
  // Field positions
  // ****************************************
  // Mode register: [2:0] mode, [4] primary enable, [5] auxiliary enable
  localparam int MODE_LSB = 0;
  localparam int EN0_BIT = 4;
  localparam int EN1_BIT = 5;
  // Status register: [0] ready0, [1] ready1, [2] error0, [3] error1, [4] missing ref (live)
  localparam int RDY0_BIT = 0;
  localparam int RDY1_BIT = 1;
  localparam int PRIMARY_ERROR_FLAG_BIT = 2;
  localparam int AUXILIARY_ERROR_FLAG_BIT = 3;
  localparam int NOREF_BIT = 4;
  localparam int NUM_EVT = 4;

  // ****************************************
  // Modes and values
  // ****************************************
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_INT_FULL = 3'h5;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_SYS_FULL = 3'h7;
  localparam logic [7:0] RATE_SLOWEST = 8'hFF;
  localparam logic [7:0] RATE_RESET = 8'h45;
  localparam logic [23:0] GAIN_UNITY = 24'h80_0000;
  localparam int GAIN_FRAC = 23;

  typedef enum logic [1:0] {
    CAL_NONE,
    CAL_INT_REF,
    CAL_EXT_PIN
  } input_sel_e;

  typedef struct packed {
    logic [23:0] ofs0;
    logic [23:0] gain0;
    logic [23:0] ofs1;
    logic [23:0] gain1;
  } coef_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [23:0] wdata;
  } reg_req_s;

endpackage

/* File: adc_calibration_control.sv */
// Purpose: Calibration control and output correction for a primary and an auxiliary converter
// Assumes: Filter words arrive with a valid pulse; factory coefficients are presented at reset release
// Notes: The analog modulator and filter live outside; this block steers them and stores results
//
// Operation
// - Four calibration modes are selected by the mode bits of the converter mode register.
// - After power-on the factory offset and gain for both converters are copied into the coefficient registers.
// - Each converter has its own software-visible offset and gain registers.
// - A calibration started with a converter enabled overwrites that converter's coefficients.
// - Zero-scale and full-scale points are each taken by running one conversion on the applied input.
// - A zero-scale result is written into the offset register of the calibrated converter.
// - A full-scale result is written into the gain register of the calibrated converter.
// - Internal modes route the internal zero or full-scale reference to the converter input.
// - Every calibration runs at the slowest filter rate whatever rate is programmed.
// - Coefficients are normalized before they scale filter words.
// - Correction subtracts the offset first and then multiplies by the gain.
// - Completion sets the converter's ready flag, which can be polled or raise the interrupt.
// - A missing reference during calibration blocks the register update and sets the error flag.
//
// Local design decisions: the register addresses and strobed register access.
module adc_calibration_control
  import cal_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire reg_req_s req,
  output logic [23:0] rd_data,
  output logic irq,
  // Factory coefficient store
  input wire coef_s factory_coef,
  // Converter side
  input wire logic [1:0] word_valid,
  input wire logic [47:0] word_data,
  input wire logic missing_reference_pin,
  output input_sel_e input_sel,
  output logic [1:0] conv_run,
  output logic [7:0] filter_rate,
  output logic [1:0] out_valid,
  output logic [47:0] out_data
);

  // ****************************************
  // Registers
  // ****************************************
  logic [5:0] converter_mode_register_r;
  logic [NUM_EVT-1:0] stat_r;
  logic [NUM_EVT-1:0] mask_r;
  logic [7:0] rate_r;
  coef_s coef_r;
  logic loaded_r;
  logic noref_s1_r;
  logic noref_r;
  logic [1:0] noref_seen_r;
  logic [NUM_EVT-1:0] evt;
  logic [2:0] mode;
  logic cal_active;
  logic is_zero;
  logic [1:0] en;

  assign mode = converter_mode_register_r[MODE_LSB +: 3];
  assign en = {converter_mode_register_r[EN1_BIT], converter_mode_register_r[EN0_BIT]};
  assign cal_active = mode[2] && (en != 2'b00);
  assign is_zero = !mode[0];

  // Missing reference is asynchronous to this clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      noref_s1_r <= 1'b0;
      noref_r <= 1'b0;
    end else begin
      noref_s1_r <= missing_reference_pin;
      noref_r <= noref_s1_r;
    end
  end

  // ****************************************
  // Converter steering
  // ****************************************
  always_comb begin
    if (!cal_active) begin
      input_sel = CAL_NONE;
    end else if (!mode[1]) begin
      input_sel = CAL_INT_REF;
    end else begin
      input_sel = CAL_EXT_PIN;
    end
  end
  assign conv_run = cal_active ? en : 2'b00;
  assign filter_rate = cal_active ? RATE_SLOWEST : rate_r;

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      converter_mode_register_r <= 6'h00;
    end else if (req.wr && req.addr == ADDR_MODE) begin
      converter_mode_register_r <= req.wdata[5:0];
    // Completion needs every enabled converter in one cycle; a lone word only updates its own coefficient
    end else if (cal_active && ((word_valid & en) == en)) begin
      converter_mode_register_r[MODE_LSB +: 3] <= MODE_IDLE;
    end
  end

  // Missing reference seen at any point of a calibration taints its result
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      noref_seen_r <= 2'b00;
    end else if (!cal_active) begin
      noref_seen_r <= 2'b00;
    end else begin
      noref_seen_r <= noref_seen_r | ({2{noref_r}} & en);
    end
  end

  // ****************************************
  // Coefficients
  // ****************************************
  // Factory values are caught one edge after reset release, never under the async reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loaded_r <= 1'b0;
      coef_r <= '0;
    end else begin
      loaded_r <= 1'b1;
      if (!loaded_r) begin
        coef_r <= factory_coef;
      end else begin
        if (req.wr && req.addr == ADDR_OFS0) coef_r.ofs0 <= req.wdata;
        if (req.wr && req.addr == ADDR_GAIN0) coef_r.gain0 <= req.wdata;
        if (req.wr && req.addr == ADDR_OFS1) coef_r.ofs1 <= req.wdata;
        if (req.wr && req.addr == ADDR_GAIN1) coef_r.gain1 <= req.wdata;
        if (cal_active && en[0] && word_valid[0] && !noref_seen_r[0] && !noref_r) begin
          if (is_zero) coef_r.ofs0 <= word_data[23:0];
          else coef_r.gain0 <= word_data[23:0];
        end
        if (cal_active && en[1] && word_valid[1] && !noref_seen_r[1] && !noref_r) begin
          if (is_zero) coef_r.ofs1 <= word_data[47:24];
          else coef_r.gain1 <= word_data[47:24];
        end
      end
    end
  end

  // ****************************************
  // Output correction
  // ****************************************
  // Gain is normalized so the unity code scales by one; product is truncated back to 24 bits
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_corr
      logic [23:0] ofs;
      logic [23:0] gain;
      logic signed [24:0] diff;
      logic signed [49:0] prod;
      assign ofs = g == 0 ? coef_r.ofs0 : coef_r.ofs1;
      assign gain = g == 0 ? coef_r.gain0 : coef_r.gain1;
      assign diff = $signed({word_data[g*24+23], word_data[g*24 +: 24]}) - $signed({ofs[23], ofs});
      assign prod = 50'(diff * $signed({1'b0, gain}));
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          out_valid[g] <= 1'b0;
          out_data[g*24 +: 24] <= 24'h00_0000;
        end else begin
          out_valid[g] <= word_valid[g] && !cal_active;
          if (word_valid[g] && !cal_active) begin
            out_data[g*24 +: 24] <= noref_r ? 24'hFF_FFFF : prod[GAIN_FRAC +: 24];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Status, mask, interrupt
  // ****************************************
  always_comb begin
    evt = '0;
    if (cal_active && (word_valid[0] && en[0])) begin
      evt[RDY0_BIT] = 1'b1;
      evt[PRIMARY_ERROR_FLAG_BIT] = noref_seen_r[0] || noref_r;
    end
    if (cal_active && (word_valid[1] && en[1])) begin
      evt[RDY1_BIT] = 1'b1;
      evt[AUXILIARY_ERROR_FLAG_BIT] = noref_seen_r[1] || noref_r;
    end
    if (!cal_active) begin
      evt[RDY0_BIT] = word_valid[0];
      evt[RDY1_BIT] = word_valid[1];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else if (req.wr && req.addr == ADDR_STAT) begin
      stat_r <= (stat_r & ~req.wdata[NUM_EVT-1:0]) | evt;
    end else begin
      stat_r <= stat_r | evt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
      rate_r <= RATE_RESET;
    end else begin
      if (req.wr && req.addr == ADDR_MASK) mask_r <= req.wdata[NUM_EVT-1:0];
      if (req.wr && req.addr == ADDR_RATE) rate_r <= req.wdata[7:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 24'h00_0000;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_MODE: rd_data <= {18'h0_0000, converter_mode_register_r};
        ADDR_STAT: rd_data <= {19'h0_0000, noref_r, stat_r};
        ADDR_MASK: rd_data <= {20'h0_0000, mask_r};
        ADDR_OFS0: rd_data <= coef_r.ofs0;
        ADDR_GAIN0: rd_data <= coef_r.gain0;
        ADDR_OFS1: rd_data <= coef_r.ofs1;
        ADDR_GAIN1: rd_data <= coef_r.gain1;
        ADDR_RATE: rd_data <= {16'h0000, rate_r};
        default: rd_data <= 24'h00_0000;
      endcase
    end else begin
      rd_data <= 24'h00_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_rate_slowest: assert property (cal_active |-> filter_rate == RATE_SLOWEST)
    else $error("calibration not at slowest rate");
  a_internal_route: assert property (cal_active && !mode[1] |-> input_sel == CAL_INT_REF)
    else $error("internal calibration not routed to reference");
  a_offset_capture: assert property (loaded_r && cal_active && is_zero && en[0] && word_valid[0]
      && !noref_seen_r[0] && !noref_r && !req.wr |=> coef_r.ofs0 == $past(word_data[23:0]))
    else $error("offset not captured");
  a_gain_capture: assert property (loaded_r && cal_active && !is_zero && en[1] && word_valid[1]
      && !noref_seen_r[1] && !noref_r && !req.wr |=> coef_r.gain1 == $past(word_data[47:24]))
    else $error("gain not captured");
  a_noref_block: assert property (loaded_r && cal_active && noref_r && !req.wr
      |=> $stable(coef_r))
    else $error("coefficient updated without reference");
  a_ready_flag: assert property (cal_active && en[0] && word_valid[0] |=> stat_r[RDY0_BIT])
    else $error("ready flag not set");
  a_idle_after: assert property (cal_active && (word_valid & en) == en && !req.wr |=> !cal_active)
    else $error("calibration did not return to idle");
  a_factory_load: assert property ($rose(loaded_r) |-> coef_r == $past(factory_coef))
    else $error("factory coefficients not loaded");
  a_irq_level: assert property (irq == |(stat_r & mask_r))
    else $error("interrupt mismatch");
  a_err_flag: assert property (cal_active && en[1] && word_valid[1] && noref_r |=> stat_r[AUXILIARY_ERROR_FLAG_BIT])
    else $error("error flag not set");

  // Mirror checks for the other converter, refused modes and the write-one clear
  a_system_route: assert property (cal_active && mode[1] |-> input_sel == CAL_EXT_PIN)
    else $error("system calibration not routed to pins");
  a_refused_mode: assert property (!mode[2] |-> conv_run == 2'b00 && input_sel == CAL_NONE)
    else $error("calibration started by a refused mode");
  a_run_enabled: assert property (cal_active |-> conv_run == en)
    else $error("run mask differs from enables");
  a_no_cal_output: assert property (cal_active |=> out_valid == 2'b00)
    else $error("calibration word passed to output");
  a_offset1_capture: assert property (loaded_r && cal_active && is_zero && en[1] && word_valid[1]
      && !noref_seen_r[1] && !noref_r && !req.wr |=> coef_r.ofs1 == $past(word_data[47:24]))
    else $error("auxiliary offset not captured");
  a_gain0_capture: assert property (loaded_r && cal_active && !is_zero && en[0] && word_valid[0]
      && !noref_seen_r[0] && !noref_r && !req.wr |=> coef_r.gain0 == $past(word_data[23:0]))
    else $error("primary gain not captured");
  a_ready1_flag: assert property (cal_active && en[1] && word_valid[1] |=> stat_r[RDY1_BIT])
    else $error("auxiliary ready flag not set");
  a_stat_clear: assert property (req.wr && req.addr == ADDR_STAT && req.wdata[RDY0_BIT]
      && !evt[RDY0_BIT] |=> !stat_r[RDY0_BIT])
    else $error("ready flag not cleared by write of one");
  a_primary_error_flag_flag: assert property (cal_active && en[0] && word_valid[0] && noref_r |=> stat_r[PRIMARY_ERROR_FLAG_BIT])
    else $error("primary error flag not set");
  a_clean_no_err: assert property (loaded_r && cal_active && en[0] && word_valid[0] && !noref_seen_r[0]
      && !noref_r && !stat_r[PRIMARY_ERROR_FLAG_BIT] |=> !stat_r[PRIMARY_ERROR_FLAG_BIT])
    else $error("error flag set with reference present");
  a_enables_kept: assert property (cal_active && (word_valid & en) == en && !req.wr |=> en == $past(en))
    else $error("enables lost at completion");
  a_rate_after: assert property (!cal_active |-> filter_rate == rate_r)
    else $error("programmed rate not restored");

  c_int_zero: cover property (cal_active && mode == MODE_INT_ZERO && word_valid[0]);
  c_sys_full: cover property (cal_active && mode == MODE_SYS_FULL && word_valid[1]);
  c_noref_cal: cover property (cal_active && noref_r ##1 stat_r[PRIMARY_ERROR_FLAG_BIT]);
  c_corrected: cover property (out_valid[0]);
  c_both_cal: cover property (cal_active && en == 2'b11 && word_valid == 2'b11);

endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the converter calibration control block
// Assumes: Register reads answer in the cycle after the read strobe
// Notes: A plain array models the register file, mask included; status lives beside it in stat_m
module tb_top
  import cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_s req = '0;
  coef_s factory_coef;
  logic [1:0] word_valid = 2'b00;
  logic [47:0] word_data = '0;
  logic missing_reference_pin = 1'b0;
  logic [23:0] rd_data;
  logic irq;
  input_sel_e input_sel;
  logic [1:0] conv_run;
  logic [1:0] out_valid;
  logic [7:0] filter_rate;
  logic [47:0] out_data;
  logic [31:0] seed = 32'h0000_0055;
  logic [23:0] regm [16];
  logic [3:0] stat_m = 4'h0;
  int num_errors = 0;
  int checks_done = 0;

  adc_calibration_control adc_calibration_control_inst (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rd_data(rd_data), .irq(irq),
    .factory_coef(factory_coef), .word_valid(word_valid), .word_data(word_data),
    .missing_reference_pin(missing_reference_pin), .input_sel(input_sel), .conv_run(conv_run),
    .filter_rate(filter_rate), .out_valid(out_valid), .out_data(out_data)
  );

  always #50 clk_sys = ~clk_sys;

  // ****************************************
  // Bus cycles and comparisons
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_pin(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic chk_reg(input logic [3:0] a, input logic [23:0] exp, input string what);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h00_0000};
    @(posedge clk_sys);
    req <= '0;
    @(negedge clk_sys);
    chk_pin(48'(rd_data), 48'(exp), what);
  endtask

  task automatic cal(input logic [2:0] m, input logic [1:0] en, input logic nr);
    logic [47:0] w;
    w = {24'(xs()), 24'(xs())};
    wr(ADDR_MODE, {18'h0, en, 1'b0, m});
    @(negedge clk_sys);
    chk_pin(48'(input_sel), 48'(m[1] ? CAL_EXT_PIN : CAL_INT_REF), "input select");
    chk_pin(48'(conv_run), 48'(en), "run");
    chk_pin(48'(filter_rate), 48'(RATE_SLOWEST), "cal rate");
    @(posedge clk_sys);
    word_valid <= en;
    word_data <= w;
    @(posedge clk_sys);
    word_valid <= 2'b00;
    for (int k = 0; k < 2; k++) begin
      if (en[k] && !nr) regm[3 + 2 * k + m[0]] = w[24 * k +: 24];
    end
    stat_m = stat_m | {(nr ? en : 2'b00), en};
    @(negedge clk_sys);
    chk_pin(48'(conv_run), 48'h0, "run after done");
    chk_reg(ADDR_MODE, {18'h0, en, 4'h0}, "mode after cal");
    for (int a = 3; a < 7; a++) chk_reg(4'(a), regm[a], "coefficient");
    chk_reg(ADDR_STAT, {19'h0, nr, stat_m}, "status");
    chk_pin(48'(irq), 48'(|(stat_m & regm[ADDR_MASK][3:0])), "irq raised");
    wr(ADDR_STAT, 24'h00_000F);
    stat_m = 4'h0;
    @(negedge clk_sys);
    chk_pin(48'(irq), 48'h0, "irq cleared");
  endtask

  // Values are kept small and positive so the model needs no sign handling
  task automatic corr(input logic nr);
    logic [23:0] ofs;
    logic [23:0] g;
    logic [23:0] wv;
    longint d;
    ofs = 24'(xs()) & 24'h0F_FFFF;
    g = (24'(xs()) & 24'h3F_FFFF) | 24'h40_0000;
    wv = ofs + (24'(xs()) & 24'h0F_FFFF);
    wr(ADDR_OFS0, ofs);
    wr(ADDR_GAIN0, g);
    wr(ADDR_OFS1, ofs);
    wr(ADDR_GAIN1, g);
    d = ((longint'(wv) - longint'(ofs)) * longint'(g)) >>> GAIN_FRAC;
    @(posedge clk_sys);
    word_valid <= 2'b11;
    word_data <= {wv, wv};
    @(posedge clk_sys);
    word_valid <= 2'b00;
    @(negedge clk_sys);
    chk_pin(48'(out_valid), 48'h3, "out valid");
    chk_pin(out_data, nr ? 48'hFFFF_FFFF_FFFF : {24'(d), 24'(d)}, "corrected word");
    chk_reg(ADDR_STAT, {19'h0, nr, 4'h3}, "ready after conversion");
    wr(ADDR_STAT, 24'h00_000F);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    #500_000;
    num_errors++;
    conclude();
  end

  initial begin
    logic [1:0] en;
    factory_coef = {xs(), xs(), xs()};
    for (int a = 0; a < 16; a++) regm[a] = 24'h00_0000;
    regm[ADDR_OFS0] = factory_coef.ofs0;
    regm[ADDR_GAIN0] = factory_coef.gain0;
    regm[ADDR_OFS1] = factory_coef.ofs1;
    regm[ADDR_GAIN1] = factory_coef.gain1;
    regm[ADDR_RATE] = 24'(RATE_RESET);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_pin(48'(filter_rate), 48'(RATE_RESET), "reset rate");
    chk_pin(48'(input_sel), 48'(CAL_NONE), "idle select");
    for (int a = 0; a < 9; a++) chk_reg(4'(a), regm[a], "after reset");
    wr(ADDR_RATE, 24'h00_0020);
    @(negedge clk_sys);
    chk_pin(48'(filter_rate), 48'h20, "programmed rate");
    wr(ADDR_MODE, 24'h00_0011);
    @(negedge clk_sys);
    chk_pin(48'(conv_run), 48'h0, "refused mode");
    // Zero-scale always precedes full-scale on the same converter
    for (int i = 0; i < 8; i++) begin
      en = (i < 4) ? 2'b01 : (i[0] ? 2'b10 : 2'b11);
      regm[ADDR_MASK] = 24'(xs() & 32'h0000_000F);
      wr(ADDR_MASK, regm[ADDR_MASK]);
      cal(3'(4 + i % 4), en, 1'b0);
    end
    @(posedge clk_sys);
    missing_reference_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cal(MODE_INT_FULL, 2'b11, 1'b1);
    corr(1'b1);
    @(posedge clk_sys);
    missing_reference_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int j = 0; j < 4; j++) corr(1'b0);
    conclude();
  end
endmodule
